// file: hw/lpoc_pkg.sv
// How it works
// [R1] dual-function pin powers up as data out or clock in, chosen by a parameter
// [R2] software flips the pin role through a configuration register bit
// [R3] host must restore data-out role before reading; no reads while clock input
// [R4] stagger applies only to ports configured as constant-current outputs
// [R5] with stagger, the ten ports start at one of eight spaced positions
// [R6] ports zero to seven all distinct; even and odd quartets evenly spaced
// [R7] intensity zero means static constant-current sink, no modulation
// [R8] sinks stay on in run, hold-off, fade-off, ramp-up; all off in shutdown
// [R9] a write to the shared level register updates several ports at once
// [R10] each port independently selects half or full sink current
// [R11] serial word: read flag, seven address bits, then data byte
// [R12] role bit cleared selects data output, needed for chaining and reads
// [R13] positions step by one eighth of 256; ports eight and nine reuse earlier ones
package lpoc_pkg;
	localparam int NUM_PORTS = 10;
	localparam logic [6:0] ADDR_PORT0 = 7'h00;
	localparam logic [6:0] ADDR_MULTI = 7'h0b;
	localparam logic [6:0] ADDR_CONFIG = 7'h10;
	localparam logic [6:0] ADDR_CURRENT_LO = 7'h13;
	localparam logic [6:0] ADDR_CURRENT_HI = 7'h14;
	localparam logic [6:0] ADDR_PORT_MODE = 7'h15;
	localparam logic [6:0] ADDR_PORT_MODE_HI = 7'h16;
	localparam int CFG_ROLE_BIT = 7;
	localparam int CFG_STAGGER_BIT = 5;
	localparam int CFG_RUN_BIT = 0;
	localparam logic [7:0] LEVEL_RESET = 8'hff;
	localparam logic [7:0] LEVEL_STATIC = 8'h00;
	localparam logic [7:0] STAGGER_STEP = 8'h20;
	localparam int PWM_DIV = 4;
	typedef enum {ST_SHUTDOWN, ST_RAMP_UP, ST_RUN, ST_HOLD_OFF, ST_FADE_OFF} lpoc_state_e;
	typedef struct packed {
		logic rd;
		logic [6:0] addr;
		logic [7:0] data;
	} lpoc_word_s;
	typedef struct packed {
		logic [9:0] sink_on;
		logic [9:0] full_scale;
	} lpoc_drive_s;
endpackage

// file: hw/lpoc_port_pwm.sv
`timescale 1ns/10ps
module lpoc_port_pwm (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// timing
	input wire logic tick,
	input wire logic [7:0] phase,
	// settings
	input wire logic [7:0] level,
	input wire logic is_cc,
	input wire logic stagger,
	input wire logic [7:0] start_pos,
	input wire logic enabled,
	// drive
	output logic sink
);
	logic [7:0] local_phase;
	// stagger offsets the count only for constant-current ports
	assign local_phase = phase - ((stagger && is_cc) ? start_pos : 8'h00); // [R4]
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sink <= 1'b0;
		end else if (!enabled || !is_cc) begin
			sink <= 1'b0;
		end else if (level == lpoc_pkg::LEVEL_STATIC) begin
			sink <= 1'b1; // [R7]
		end else if (tick) begin
			sink <= (local_phase < level); // [R5]
		end
	end
endmodule

// file: hw/lpoc_top.sv
`timescale 1ns/10ps
module lpoc_top #(
	parameter bit ROLE_DEFAULT = 1'b0,
	parameter int NUM_PORTS = lpoc_pkg::NUM_PORTS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// serial interface
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	// dual-function pin
	input wire logic dual_function_pin_in,
	output logic dual_function_pin_out,
	output logic dual_function_pin_oe_n,
	// sequencing state from the fade controller
	input wire logic fade_done,
	input wire logic ramp_done,
	input wire logic hold_done,
	// port lines
	output logic [9:0] port_lines_sink,
	output logic [9:0] port_lines_full
);
	logic [15:0] shift_reg;
	logic sclk_reg;
	logic cs_n_reg;
	logic [7:0] level_reg [NUM_PORTS];
	logic [7:0] config_reg;
	logic [9:0] full_reg;
	logic [9:0] cc_mode_reg;
	logic [7:0] phase_reg;
	logic [1:0] div_reg;
	logic pwm_clk_reg;
	logic tick;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic sink_on;
	logic [7:0] read_data;
	logic [9:0] sink_raw;
	lpoc_pkg::lpoc_word_s word;
	lpoc_pkg::lpoc_state_e state_reg;
	lpoc_pkg::lpoc_drive_s drive;

	assign word = shift_reg;
	assign sclk_rise = sclk && !sclk_reg;
	assign sclk_fall = !sclk && sclk_reg;
	assign cs_rise = cs_n && !cs_n_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
		end else begin
			sclk_reg <= sclk;
			cs_n_reg <= cs_n;
		end
	end

	// shift in, and load read data into the low byte at the end of a read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= 16'h0000;
		end else if (!cs_n && sclk_rise) begin
			shift_reg <= {shift_reg[14:0], din};
		end else if (cs_rise && word.rd) begin
			shift_reg <= {shift_reg[15:8], read_data}; // [R11]
		end
	end

	// read mux
	always_comb begin
		read_data = 8'h00;
		if (word.addr < 7'(NUM_PORTS)) begin
			read_data = level_reg[word.addr[3:0]];
		end else if (word.addr == lpoc_pkg::ADDR_MULTI) begin
			read_data = level_reg[0];
		end else if (word.addr == lpoc_pkg::ADDR_CONFIG) begin
			read_data = config_reg;
		end else if (word.addr == lpoc_pkg::ADDR_CURRENT_LO) begin
			read_data = full_reg[7:0];
		end else if (word.addr == lpoc_pkg::ADDR_CURRENT_HI) begin
			read_data = {6'h00, full_reg[9:8]};
		end else if (word.addr == lpoc_pkg::ADDR_PORT_MODE) begin
			read_data = cc_mode_reg[7:0];
		end else if (word.addr == lpoc_pkg::ADDR_PORT_MODE_HI) begin
			read_data = {6'h00, cc_mode_reg[9:8]};
		end
	end

	// intensity registers; multi-port address writes ports zero to three together
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				level_reg[i] <= lpoc_pkg::LEVEL_RESET;
			end
		end else if (cs_rise && !word.rd) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (word.addr == 7'(i)) begin
					level_reg[i] <= word.data;
				end else if (word.addr == lpoc_pkg::ADDR_MULTI && i < 4) begin
					level_reg[i] <= word.data; // [R9]
				end
			end
		end
	end

	// configuration, current and mode registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			config_reg <= {ROLE_DEFAULT, 7'h00}; // [R1]
			full_reg <= 10'h3ff;
			cc_mode_reg <= 10'h000;
		end else if (cs_rise && !word.rd) begin
			if (word.addr == lpoc_pkg::ADDR_CONFIG) begin
				config_reg <= word.data; // [R2]
			end else if (word.addr == lpoc_pkg::ADDR_CURRENT_LO) begin
				full_reg[7:0] <= word.data; // [R10]
			end else if (word.addr == lpoc_pkg::ADDR_CURRENT_HI) begin
				full_reg[9:8] <= word.data[1:0]; // [R10]
			end else if (word.addr == lpoc_pkg::ADDR_PORT_MODE) begin
				cc_mode_reg[7:0] <= word.data;
			end else if (word.addr == lpoc_pkg::ADDR_PORT_MODE_HI) begin
				cc_mode_reg[9:8] <= word.data[1:0];
			end
		end
	end

	// pin role: cleared bit drives data out; readback only works in that role
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dual_function_pin_out <= 1'b0;
		end else if (!cs_n && sclk_fall) begin
			// serial clock is ignored while deselected, so a shared bus cannot disturb the pin
			dual_function_pin_out <= shift_reg[15]; // [R12]
		end
	end
	assign dual_function_pin_oe_n = config_reg[lpoc_pkg::CFG_ROLE_BIT]; // [R3]

	// pwm time base: external clock edges or internal divider
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 2'h0;
			pwm_clk_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			pwm_clk_reg <= dual_function_pin_in;
		end
	end
	assign tick = config_reg[lpoc_pkg::CFG_ROLE_BIT] ? (dual_function_pin_in && !pwm_clk_reg)
		: (div_reg == 2'(lpoc_pkg::PWM_DIV - 1));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= 8'h00;
		end else if (tick) begin
			phase_reg <= phase_reg + 8'h01;
		end
	end

	// run sequencing; fade controller reports when ramp-up, hold-off and fade-off end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= lpoc_pkg::ST_SHUTDOWN;
		end else begin
			case (state_reg)
				lpoc_pkg::ST_SHUTDOWN: begin
					if (config_reg[lpoc_pkg::CFG_RUN_BIT]) begin
						state_reg <= lpoc_pkg::ST_RAMP_UP;
					end
				end
				lpoc_pkg::ST_RAMP_UP: begin
					if (ramp_done) begin
						state_reg <= lpoc_pkg::ST_RUN;
					end
				end
				lpoc_pkg::ST_RUN: begin
					if (!config_reg[lpoc_pkg::CFG_RUN_BIT]) begin
						state_reg <= lpoc_pkg::ST_HOLD_OFF;
					end
				end
				lpoc_pkg::ST_HOLD_OFF: begin
					if (hold_done) begin
						state_reg <= lpoc_pkg::ST_FADE_OFF;
					end
				end
				lpoc_pkg::ST_FADE_OFF: begin
					if (fade_done) begin
						state_reg <= lpoc_pkg::ST_SHUTDOWN;
					end
				end
				default: begin
					state_reg <= lpoc_pkg::ST_SHUTDOWN;
				end
			endcase
		end
	end
	assign sink_on = (state_reg != lpoc_pkg::ST_SHUTDOWN); // [R8]

	// start positions: k steps of one eighth period; 8 and 9 reuse 0 and 1
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			// one eighth per port keeps both quartets a quarter period apart
			localparam logic [2:0] SLOT = 3'(g % 8); // [R6]
			lpoc_port_pwm u_pwm (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.tick(tick),
				.phase(phase_reg),
				.level(level_reg[g]),
				.is_cc(cc_mode_reg[g]),
				.stagger(config_reg[lpoc_pkg::CFG_STAGGER_BIT]),
				.start_pos(8'(SLOT * lpoc_pkg::STAGGER_STEP)), // [R13]
				.enabled(sink_on),
				.sink(sink_raw[g])
			);
		end
	endgenerate

	assign drive = {sink_raw, full_reg};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			port_lines_sink <= 10'h000;
			port_lines_full <= 10'h000;
		end else begin
			port_lines_sink <= drive.sink_on;
			port_lines_full <= drive.full_scale & cc_mode_reg; // [R10]
		end
	end
endmodule

// file: test/lpoc_top_monitor.sv
`timescale 1ns/10ps
module lpoc_top_monitor #(
	parameter bit ROLE_DEFAULT = 1'b0
) (
	// watched ports
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dual_function_pin_out,
	input wire logic dual_function_pin_oe_n,
	input wire logic [9:0] port_lines_sink,
	input wire logic [9:0] port_lines_full
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// three low cycles leave room for the device's input sampling delay
	sequence s_cs_busy; !cs_n [*3]; endsequence
	sequence s_cs_idle; cs_n ##1 cs_n; endsequence
	sequence s_sclk_high; sclk ##1 sclk; endsequence
	chk_role_default: assert property ($rose(nrst) |-> dual_function_pin_oe_n == ROLE_DEFAULT)
		else $error("pin role not at default after reset");
	chk_sink_reset: assert property ($rose(nrst) |-> port_lines_sink == 10'h000)
		else $error("port sinking right after reset");
	chk_full_reset: assert property ($rose(nrst) |-> port_lines_full == 10'h000)
		else $error("full scale set right after reset");
	chk_out_reset: assert property ($rose(nrst) |-> !dual_function_pin_out)
		else $error("data out not low after reset");
	chk_role_quiet: assert property (s_cs_busy |=> $stable(dual_function_pin_oe_n))
		else $error("pin role changed inside a word");
	chk_full_quiet: assert property (s_cs_busy |=> $stable(port_lines_full))
		else $error("current scale changed inside a word");
	chk_out_on_fall: assert property (s_sclk_high |-> $stable(dual_function_pin_out))
		else $error("data out moved while clock high");
	chk_out_idle: assert property (s_cs_idle |=> $stable(dual_function_pin_out))
		else $error("data out moved while deselected");
endmodule
bind lpoc_top lpoc_top_monitor #(.ROLE_DEFAULT(ROLE_DEFAULT)) u_lpoc_top_monitor (
	.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
	.dual_function_pin_out(dual_function_pin_out),
	.dual_function_pin_oe_n(dual_function_pin_oe_n),
	.port_lines_sink(port_lines_sink), .port_lines_full(port_lines_full));

// file: test/lpoc_host_model.sv
`timescale 1ns/10ps
module lpoc_host_model (
	// clock
	input wire logic ref_clk,
	// serial lines
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// each level held two cycles since the device samples on its own clock
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			repeat (2) @(negedge ref_clk);
			sclk = 1'b1;
			repeat (2) @(negedge ref_clk);
			r[i] = dout;
			sclk = 1'b0;
		end
		repeat (2) @(negedge ref_clk);
		cs_n = 1'b1;
		din = ~din;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

// file: test/lpoc_top_bench.sv
`timescale 1ns/10ps
module lpoc_top_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, cs_n, din, dfp_out, oe_n;
	logic dfp_in = 1'b0;
	logic fade_done = 1'b0;
	logic ramp_done = 1'b1;
	logic hold_done = 1'b0;
	logic [9:0] sink, full;
	logic [15:0] r;
	logic [7:0] d;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) dfp_in <= ~dfp_in;
	lpoc_top #(.ROLE_DEFAULT(1'b1)) u_lpoc_top (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dual_function_pin_in(dfp_in), .dual_function_pin_out(dfp_out),
		.dual_function_pin_oe_n(oe_n), .fade_done(fade_done), .ramp_done(ramp_done),
		.hold_done(hold_done), .port_lines_sink(sink), .port_lines_full(full));
	// a released pin shows the inverse so stale data cannot pass
	lpoc_host_model u_lpoc_host_model (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(oe_n ? ~dfp_out : dfp_out));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		u_lpoc_host_model.xfer({1'b0, a, v}, r);
	endtask
	task automatic rd(input logic [6:0] a);
		u_lpoc_host_model.xfer({1'b1, a, 8'h00}, r);
		u_lpoc_host_model.xfer({1'b1, a, 8'h00}, r);
		d = r[7:0];
	endtask
	task automatic results;
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_role;
		chk("oe_n", 16'h1, {15'h0, oe_n});
		wr(lpoc_pkg::ADDR_CONFIG, 8'h00);
		chk("oe_n", 16'h0, {15'h0, oe_n});
		wr(lpoc_pkg::ADDR_CONFIG, 8'h80);
		chk("oe_n", 16'h1, {15'h0, oe_n});
		wr(lpoc_pkg::ADDR_CONFIG, 8'h00);
		chk("oe_n", 16'h0, {15'h0, oe_n});
	endtask
	task automatic t_regs;
		rd(lpoc_pkg::ADDR_PORT0);
		chk("level0", {8'h0, lpoc_pkg::LEVEL_RESET}, {8'h0, d});
		wr(lpoc_pkg::ADDR_MULTI, lpoc_pkg::LEVEL_STATIC);
		rd(7'h03);
		chk("level3", 16'h0, {8'h0, d});
		rd(7'h04);
		chk("level4", 16'hff, {8'h0, d});
		rd(7'h7f);
		chk("unmapped", 16'h0, {8'h0, d});
	endtask
	task automatic t_static;
		logic [3:0] acc;
		wr(lpoc_pkg::ADDR_PORT_MODE, 8'hff);
		wr(lpoc_pkg::ADDR_PORT_MODE_HI, 8'h03);
		wr(lpoc_pkg::ADDR_CURRENT_LO, 8'hfe);
		chk("off", 16'h0, {6'h0, sink});
		ramp_done = 1'b0;
		wr(lpoc_pkg::ADDR_CONFIG, 8'h01);
		repeat (20) @(negedge ref_clk);
		chk("rampup", 16'hf, {12'h0, sink[3:0]});
		ramp_done = 1'b1;
		repeat (40) @(negedge ref_clk);
		acc = 4'hf;
		repeat (1100) @(negedge ref_clk) acc &= sink[3:0];
		chk("static", 16'hf, {12'h0, acc});
		chk("full", 16'h3fe, {6'h0, full});
		wr(lpoc_pkg::ADDR_CONFIG, 8'h00);
		repeat (20) @(negedge ref_clk);
		chk("holdoff", 16'hf, {12'h0, sink[3:0]});
		hold_done = 1'b1;
		repeat (20) @(negedge ref_clk);
		chk("fadeoff", 16'hf, {12'h0, sink[3:0]});
		fade_done = 1'b1;
		repeat (20) @(negedge ref_clk);
		chk("shutdown", 16'h0, {6'h0, sink});
		{hold_done, fade_done} = 2'b00;
	endtask
	// first sink rise of each port against port zero; unit is cycles per eighth period
	task automatic starts(input int unit);
		int t[10];
		int span;
		logic [9:0] prev;
		span = 8 * unit;
		repeat (100) @(negedge ref_clk);
		t = '{default: -1};
		prev = sink;
		for (int k = 0; k < 1100; k++) begin
			@(negedge ref_clk);
			for (int g = 0; g < 10; g++) if (sink[g] && !prev[g] && t[g] < 0) t[g] = k;
			prev = sink;
		end
		for (int g = 1; g < 10; g++) chk("start", 16'((g % 8) * unit),
			16'((t[g] - t[0] + span) % span));
	endtask
	task automatic t_stagger;
		wr(lpoc_pkg::ADDR_MULTI, 8'h80);
		for (int g = 4; g < 10; g++) wr(7'(g), 8'h80);
		wr(lpoc_pkg::ADDR_CONFIG, 8'h21);
		// internal tick every PWM_DIV cycles, 256 ticks a period
		starts(lpoc_pkg::PWM_DIV * lpoc_pkg::STAGGER_STEP);
	endtask
	// external clock rises every second cycle; no reads are possible in this role
	task automatic t_ext_clock;
		logic [1:0] acc;
		wr(lpoc_pkg::ADDR_CONFIG, 8'ha1);
		chk("oe_n", 16'h1, {15'h0, oe_n});
		starts(2 * lpoc_pkg::STAGGER_STEP);
		wr(lpoc_pkg::ADDR_PORT_MODE_HI, 8'h00);
		repeat (8) @(negedge ref_clk);
		acc = 2'h0;
		repeat (600) @(negedge ref_clk) acc |= sink[9:8];
		chk("non_cc", 16'h0, {14'h0, acc});
		chk("full", 16'h0fe, {6'h0, full});
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		@(negedge ref_clk);
		t_role();
		t_regs();
		t_static();
		t_stagger();
		t_ext_clock();
		results();
	end
endmodule
